// [fifo_ctl_pkg.sv]
// Functional notes
// - differential bit swaps transceiver mode
// - 32-bit stack holds call return address
// - return loads stack into instruction pointer
// - flush bit moves fifo from next address
// - clear bit resets pointers and offset count
// - clear bit drops by itself when done
// - six-bit offset counts core byte moves
// - offset counter loads the written value
// - status read has no side effect
// - abort bit aborts and raises dma interrupt
// - aborted interrupts repeat while bit stays set
// - pointer empty flag when both pointers empty
// - bus pending flag from eight conditions
// - dma pending flag from five causes
// - direction high means bus to host
// - byte counter drops by bytes moved
package fifo_ctl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_STACK    = 8'h1C;
   localparam logic [7:0]  IDX_FIFO     = 8'h20;
   localparam logic [7:0]  IDX_INTERRUPT_STATUS_ABORT    = 8'h21;
   localparam logic [7:0]  IDX_LINK     = 8'h22;
   localparam logic [7:0]  IDX_BCNT     = 8'h24;
   localparam int          FLUSH_BIT    = 7;
   localparam int          CLEAR_BIT    = 6;
   localparam int          OFS_W        = 6;
   localparam int          ABORT_BIT    = 7;
   localparam int          PRE_BIT      = 2;
   localparam int          SIP_BIT      = 1;
   localparam int          DIP_BIT      = 0;
   localparam int          DIFFERENTIAL_SELECT_BIT     = 0;
   localparam int          DIR_BIT      = 1;
   localparam int          BCNT_W       = 24;
   localparam int          BUS_CONDS    = 8;
   localparam int          DMA_CONDS    = 4;
   localparam logic [31:0] STACK_RST    = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RST     = 8'h00;
   localparam logic [23:0] BCNT_RST     = 24'h00_0000;
   localparam int          CLEAR_CYCLES = 2;
   typedef enum logic [2:0]
   {
      CLR_IDLE = 3'b001,
      CLR_BUSY = 3'b010,
      CLR_DONE = 3'b100
   } clr_state_t;
endpackage

// [offset_counter.sv]
`timescale 1ns/1ns
module offset_counter
   import fifo_ctl_pkg::*;
#(
   parameter int WIDTH = OFS_W
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // control
   input  wire logic             clear,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   input  wire logic             step,
   // count
   output logic      [WIDTH-1:0] count_ff
);
   logic [WIDTH-1:0] nxt_count;

   // clear wins, then software write over step, so a read-back value is preserved exactly
   assign nxt_count = clear ? '0 :
                      load  ? load_value :
                      step  ? WIDTH'(count_ff + 1'b1) : count_ff;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         count_ff <= '0;
      else
         count_ff <= nxt_count;
   end
endmodule

// [clear_sequencer.sv]
`timescale 1ns/1ns
module clear_sequencer
   import fifo_ctl_pkg::*;
#(
   parameter int CYCLES = CLEAR_CYCLES
)
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // request and progress
   input  wire logic start,
   output logic      clearing_ff,
   output logic      done_ff
);
   clr_state_t  state_ff;
   clr_state_t  nxt_state;
   logic [3:0]  cnt_ff;
   logic [3:0]  nxt_cnt;
   wire         last = (cnt_ff == 4'(CYCLES - 1));

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         CLR_IDLE:
            if (start)
            begin
               nxt_state = CLR_BUSY;
               nxt_cnt   = 4'h0;
            end
         CLR_BUSY:
            if (last)
               nxt_state = CLR_DONE;
            else
               nxt_cnt = 4'(cnt_ff + 1'b1);
         CLR_DONE:
            nxt_state = CLR_IDLE;
         default:
            nxt_state = CLR_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff    <= CLR_IDLE;
         cnt_ff      <= 4'h0;
         clearing_ff <= 1'b0;
         done_ff     <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         clearing_ff <= (nxt_state == CLR_BUSY);
         done_ff     <= (nxt_state == CLR_DONE);
      end
   end
endmodule

// [fifo_control_status.sv]
`timescale 1ns/1ns
module fifo_control_status
   import fifo_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   // wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [9:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // instruction engine
   input  wire logic                 call_strobe,
   input  wire logic [31:0]          call_address,
   input  wire logic                 return_strobe,
   output logic                      instr_pointer_load,
   output logic      [31:0]          instr_pointer_value,
   input  wire logic                 instr_pointer_empty,
   input  wire logic                 pointer_save_empty,
   // data path
   input  wire logic                 core_byte_strobe,
   input  wire logic                 host_xfer_strobe,
   input  wire logic [2:0]           host_xfer_bytes,
   input  wire logic [31:0]          next_address_pointer,
   output logic                      flush_request,
   output logic      [31:0]          flush_start_address,
   output logic                      transfer_direction,
   output logic                      fifo_pointers_clear,
   // interrupt sources and status reads elsewhere
   input  wire logic [BUS_CONDS-1:0] bus_conditions,
   input  wire logic [DMA_CONDS-1:0] dma_conditions,
   input  wire logic                 bus_status_read,
   input  wire logic                 transfer_status_read,
   // mode and abort
   output logic                      differential_select,
   output logic                      abort_request
);
   logic [31:0]       stack_ff;
   logic [BCNT_W-1:0] bcnt_ff;
   logic [BCNT_W-1:0] nxt_bcnt;
   logic [OFS_W-1:0]  offset;
   logic              clear_bit_ff;
   logic              sip_ff;
   logic              dip_ff;
   logic              pre_ff;
   logic              clearing;
   logic              clear_done;
   logic [31:0]       rd_mux;

   wire        req      = wb_cyc_i & wb_stb_i;
   wire [7:0]  idx      = wb_adr_i[9:2];
   wire        wr       = req & wb_we_i & wb_ack_o;
   wire        wr_stack = wr & (idx == IDX_STACK);
   wire        wr_fifo  = wr & (idx == IDX_FIFO) & wb_sel_i[0];
   wire        wr_interrupt_status_abort = wr & (idx == IDX_INTERRUPT_STATUS_ABORT) & wb_sel_i[0];
   wire        wr_link  = wr & (idx == IDX_LINK) & wb_sel_i[0];
   wire        wr_bcnt  = wr & (idx == IDX_BCNT);
   wire        clr_set  = wr_fifo & wb_dat_i[CLEAR_BIT];
   wire        abort_ev = abort_request;
   wire        dip_set  = abort_ev | (|dma_conditions);
   wire        sip_set  = |bus_conditions;
   wire [7:0]  fifo_rd  = {flush_request, clear_bit_ff, offset};
   wire [7:0]  interrupt_status_abort_rd = {abort_request, 4'h0, pre_ff, sip_ff, dip_ff};
   wire [7:0]  link_rd  = {6'h00, transfer_direction, differential_select};

   // reads only select data; no flag changes on a read
   assign rd_mux = (idx == IDX_STACK) ? stack_ff :
                   (idx == IDX_FIFO)  ? {24'h00_0000, fifo_rd} :
                   (idx == IDX_INTERRUPT_STATUS_ABORT) ? {24'h00_0000, interrupt_status_abort_rd} :
                   (idx == IDX_LINK)  ? {24'h00_0000, link_rd} :
                   (idx == IDX_BCNT)  ? {8'h00, bcnt_ff} : 32'h0000_0000;

   // byte counter: bus write wins, else drop by bytes moved
   assign nxt_bcnt = wr_bcnt ? wb_dat_i[BCNT_W-1:0] :
                     host_xfer_strobe ? BCNT_W'(bcnt_ff - {21'h00_0000, host_xfer_bytes}) : bcnt_ff;

   // single wait state: ack one cycle after the request, dropped next
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_stack_lane
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               stack_ff[8*b +: 8] <= STACK_RST[8*b +: 8];
            else if (call_strobe)
               stack_ff[8*b +: 8] <= call_address[8*b +: 8];
            else if (wr_stack & wb_sel_i[b])
               stack_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
         end
      end
   endgenerate

   // return jumps through the saved address
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         instr_pointer_load  <= 1'b0;
         instr_pointer_value <= STACK_RST;
      end
      else
      begin
         instr_pointer_load <= return_strobe;
         if (return_strobe)
            instr_pointer_value <= stack_ff;
      end
   end

   // flush stays until software writes it back
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flush_request       <= BYTE_RST[FLUSH_BIT];
         flush_start_address <= STACK_RST;
      end
      else if (wr_fifo)
      begin
         flush_request <= wb_dat_i[FLUSH_BIT];
         if (wb_dat_i[FLUSH_BIT] & ~flush_request)
            flush_start_address <= next_address_pointer;
      end
   end

   // clear bit: set wins over the done that drops it
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clear_bit_ff        <= BYTE_RST[CLEAR_BIT];
         fifo_pointers_clear <= 1'b0;
      end
      else
      begin
         clear_bit_ff        <= clr_set | (clear_bit_ff & ~clear_done);
         fifo_pointers_clear <= clearing;
      end
   end

   clear_sequencer #(
      .CYCLES      (CLEAR_CYCLES)
   ) u_clear (
      .clock       (clock),
      .rst_n       (rst_n),
      .start       (clr_set),
      .clearing_ff (clearing),
      .done_ff     (clear_done)
   );

   // counter zeroed with the fifo pointers
   offset_counter #(
      .WIDTH      (OFS_W)
   ) u_offset (
      .clock      (clock),
      .rst_n      (rst_n),
      .clear      (clearing),
      .load       (wr_fifo),
      .load_value (wb_dat_i[OFS_W-1:0]),
      .step       (core_byte_strobe),
      .count_ff   (offset)
   );

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         abort_request       <= 1'b0;
         differential_select <= 1'b0;
         transfer_direction  <= 1'b0;
         bcnt_ff             <= BCNT_RST;
         pre_ff              <= 1'b0;
      end
      else
      begin
         if (wr_interrupt_status_abort)
            abort_request <= wb_dat_i[ABORT_BIT];
         if (wr_link)
         begin
            differential_select <= wb_dat_i[DIFFERENTIAL_SELECT_BIT];
            transfer_direction  <= wb_dat_i[DIR_BIT];
         end
         bcnt_ff <= nxt_bcnt;
         pre_ff  <= instr_pointer_empty & pointer_save_empty;
      end
   end

   // pending flags: new condition wins over the clearing status read
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sip_ff <= 1'b0;
         dip_ff <= 1'b0;
      end
      else
      begin
         sip_ff <= sip_set | (sip_ff & ~bus_status_read);
         // abort held high keeps re-raising the dma flag
         dip_ff <= dip_set | (dip_ff & ~transfer_status_read);
      end
   end

   sequence s_clear_req;
      clr_set;
   endsequence

   sequence s_clear_work;
      ##[1:3] fifo_pointers_clear ##[1:8] !clear_bit_ff;
   endsequence

   property p_differential_select_mode;
      @(posedge clock) disable iff (!rst_n)
      wr_link |=> differential_select == $past(wb_dat_i[DIFFERENTIAL_SELECT_BIT]);
   endproperty
   a_differential_select_mode: assert property (p_differential_select_mode) else $error("differential select not loaded");

   property p_return_load;
      @(posedge clock) disable iff (!rst_n)
      return_strobe |=> instr_pointer_load && instr_pointer_value == $past(stack_ff);
   endproperty
   a_return_load: assert property (p_return_load) else $error("return did not load stack");

   property p_flush_hold;
      @(posedge clock) disable iff (!rst_n)
      (flush_request && !wr_fifo) |=> flush_request;
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("flush dropped without write");

   property p_clear_cycle;
      @(posedge clock) disable iff (!rst_n)
      s_clear_req |-> s_clear_work;
   endproperty
   a_clear_cycle: assert property (p_clear_cycle) else $error("clear did not run and end");

   property p_clear_zero;
      @(posedge clock) disable iff (!rst_n)
      clearing |=> offset == '0;
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("offset not cleared");

   property p_offset_step;
      @(posedge clock) disable iff (!rst_n)
      (core_byte_strobe && !wr_fifo && !clearing) |=> offset == OFS_W'($past(offset) + 1'b1);
   endproperty
   a_offset_step: assert property (p_offset_step) else $error("offset did not count");

   property p_offset_load;
      @(posedge clock) disable iff (!rst_n)
      (wr_fifo && !clearing) |=> offset == $past(wb_dat_i[OFS_W-1:0]);
   endproperty
   a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

   property p_abort_repeat;
      @(posedge clock) disable iff (!rst_n)
      abort_request [*2] |-> dip_ff;
   endproperty
   a_abort_repeat: assert property (p_abort_repeat) else $error("abort not pending");

   property p_bus_pending;
      @(posedge clock) disable iff (!rst_n)
      sip_set |=> sip_ff;
   endproperty
   a_bus_pending: assert property (p_bus_pending) else $error("bus pending lost");

   property p_bcnt_drop;
      @(posedge clock) disable iff (!rst_n)
      (host_xfer_strobe && !wr_bcnt) |=> bcnt_ff == BCNT_W'($past(bcnt_ff) - $past(host_xfer_bytes));
   endproperty
   a_bcnt_drop: assert property (p_bcnt_drop) else $error("byte counter wrong");

   property p_reserved_zero;
      @(posedge clock) disable iff (!rst_n)
      (wb_ack_o && !wb_we_i && idx == IDX_INTERRUPT_STATUS_ABORT) |-> wb_dat_o[6:3] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
endmodule

// [engine_model.sv]
`timescale 1ns/1ns
module engine_model
   import fifo_ctl_pkg::*;
(
   // clock
   input  wire logic                 clock,
   // instruction engine
   output logic                      call_strobe,
   output logic      [31:0]          call_address,
   output logic                      return_strobe,
   output logic                      instr_pointer_empty,
   output logic                      pointer_save_empty,
   // data path
   output logic                      core_byte_strobe,
   output logic                      host_xfer_strobe,
   output logic      [2:0]           host_xfer_bytes,
   output logic      [31:0]          next_address_pointer,
   // interrupt sources and status reads
   output logic      [BUS_CONDS-1:0] bus_conditions,
   output logic      [DMA_CONDS-1:0] dma_conditions,
   output logic                      bus_status_read,
   output logic                      transfer_status_read
);
   logic [5:0] strobe_ff;
   assign call_strobe          = strobe_ff[0];
   assign return_strobe        = strobe_ff[1];
   assign core_byte_strobe     = strobe_ff[2];
   assign host_xfer_strobe     = strobe_ff[3];
   assign bus_status_read      = strobe_ff[4];
   assign transfer_status_read = strobe_ff[5];
   initial
   begin
      strobe_ff = 6'h00;
      {call_address, next_address_pointer, host_xfer_bytes} = '0;
      {instr_pointer_empty, pointer_save_empty, bus_conditions, dma_conditions} = '0;
   end
   // one strobe high for a number of edges, launched after an edge
   task pulse(input int k, input int n);
      @(posedge clock);
      strobe_ff <= 6'h01 << k;
      repeat (n) @(posedge clock);
      strobe_ff <= 6'h00;
   endtask
   // conditions are one-cycle pulses, never held
   task raise(input logic [BUS_CONDS-1:0] b, input logic [DMA_CONDS-1:0] d);
      @(posedge clock);
      bus_conditions <= b;
      dma_conditions <= d;
      @(posedge clock);
      bus_conditions <= '0;
      dma_conditions <= '0;
   endtask
endmodule

// [test_fifo_control_status.sv]
`timescale 1ns/1ns
module test_fifo_control_status;
   import fifo_ctl_pkg::*;
   logic                 clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0]           wb_adr_i;
   logic [3:0]           wb_sel_i;
   logic [31:0]          wb_dat_i, wb_dat_o, call_address, next_address_pointer, rd;
   logic [31:0]          instr_pointer_value, flush_start_address;
   logic                 call_strobe, return_strobe, instr_pointer_load, instr_pointer_empty;
   logic                 pointer_save_empty, core_byte_strobe, host_xfer_strobe, flush_request;
   logic                 transfer_direction, fifo_pointers_clear, bus_status_read;
   logic                 transfer_status_read, differential_select, abort_request;
   logic [2:0]           host_xfer_bytes;
   logic [BUS_CONDS-1:0] bus_conditions;
   logic [DMA_CONDS-1:0] dma_conditions;
   int                   n_mismatch, comparisons, clr_seen;

   fifo_control_status DUT (.*);
   engine_model m (.*);

   always #10 clock = ~clock;
   always @(posedge clock) if (fifo_pointers_clear === 1'b1) clr_seen <= clr_seen + 1;

   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one classic cycle; ack is awaited, never assumed
   task wb(input logic we, input logic [7:0] idx, input logic [3:0] sel, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= d;
      n = 0;
      do begin @(posedge clock); n++; end while (wb_ack_o !== 1'b1 && n < 20);
      // a missing ack ends the run; nothing may follow the closing report
      if (wb_ack_o !== 1'b1)
      begin
         n_mismatch++;
         wrap_up;
      end
      else
      begin
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i  <= 1'b0;
         @(posedge clock);
      end
   endtask

   task rdchk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp, input string name);
      wb(1'b0, idx, 4'hF, 32'h0);
      check(name, rd & mask, exp);
   endtask

   task t_regs;
      rdchk(IDX_FIFO, 32'hFF, 32'h00, "fifo reset");
      wb(1'b1, 8'h3F, 4'hF, 32'hFFFF_FFFF);
      rdchk(8'h3F, 32'hFFFF_FFFF, 32'h0, "unmapped");
      wb(1'b1, IDX_LINK, 4'h1, 32'h3);
      check("differential", differential_select, 32'h1);
      check("direction", transfer_direction, 32'h1);
      wb(1'b1, IDX_LINK, 4'h1, 32'h0);
      check("single ended", differential_select, 32'h0);
   endtask

   task t_stack;
      wb(1'b1, IDX_STACK, 4'hF, 32'h1234_5678);
      wb(1'b1, IDX_STACK, 4'h1, 32'hFFFF_FFFF);
      rdchk(IDX_STACK, 32'hFFFF_FFFF, 32'h1234_56FF, "stack lanes");
      m.call_address <= 32'hCAFE_0004;
      m.pulse(0, 1);
      rdchk(IDX_STACK, 32'hFFFF_FFFF, 32'hCAFE_0004, "stack call");
      m.pulse(1, 1);
      @(posedge clock);
      check("ip load", instr_pointer_load, 32'h1);
      check("ip value", instr_pointer_value, 32'hCAFE_0004);
      @(posedge clock);
      check("ip load end", instr_pointer_load, 32'h0);
   endtask

   task t_fifo;
      m.next_address_pointer <= 32'h0000_8000;
      wb(1'b1, IDX_FIFO, 4'h1, 32'h80);
      check("flush", flush_request, 32'h1);
      check("flush start", flush_start_address, 32'h0000_8000);
      wb(1'b1, IDX_FIFO, 4'h1, 32'h3E);
      check("flush off", flush_request, 32'h0);
      // 3E plus three bytes wraps through 3F to 01
      m.pulse(2, 3);
      rdchk(IDX_FIFO, 32'h3F, 32'h01, "offset wrap");
      wb(1'b1, IDX_FIFO, 4'h1, 32'h15);
      rdchk(IDX_FIFO, 32'hFF, 32'h15, "offset load");
      rdchk(IDX_FIFO, 32'hFF, 32'h15, "offset stable");
      clr_seen = 0;
      wb(1'b1, IDX_FIFO, 4'h1, 32'h40);
      repeat (8) @(posedge clock);
      check("clear cycles", clr_seen, CLEAR_CYCLES);
      rdchk(IDX_FIFO, 32'hFF, 32'h00, "clear done");
   endtask

   task t_bcnt;
      wb(1'b1, IDX_BCNT, 4'hF, 32'h0000_0100);
      m.host_xfer_bytes <= 3'h4;
      m.pulse(3, 1);
      rdchk(IDX_BCNT, 32'hFF_FFFF, 32'h00_00FC, "byte count");
   endtask

   // software residual arithmetic on values read back
   task t_residual;
      logic [5:0] ofs;
      logic [5:0] cnt;
      wb(1'b1, IDX_BCNT, 4'hF, 32'h0000_0106);
      m.host_xfer_bytes <= 3'h4;
      m.pulse(3, 1);
      wb(1'b1, IDX_FIFO, 4'h1, 32'h05);
      rdchk(IDX_FIFO, 32'h3F, 32'h05, "residual offset");
      ofs = rd[5:0];
      rdchk(IDX_BCNT, 32'h3F, 32'h02, "residual count");
      cnt = rd[5:0];
      check("send residual", (ofs - cnt) & 6'h3F, 32'h03);
      wb(1'b1, IDX_BCNT, 4'hF, 32'h0000_0025);
      rdchk(IDX_BCNT, 32'h3F, 32'h25, "receive count");
      cnt = rd[5:0];
      check("receive residual", (cnt - ofs) & 6'h3F, 32'h20);
   endtask

   task t_status;
      m.instr_pointer_empty <= 1'b1;
      m.pointer_save_empty  <= 1'b1;
      repeat (2) @(posedge clock);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h4, 32'h4, "ptr empty");
      m.pointer_save_empty <= 1'b0;
      repeat (2) @(posedge clock);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h4, 32'h0, "ptr busy");
      for (int i = 0; i < BUS_CONDS; i++)
      begin
         m.raise(8'h01 << i, 4'h0);
         rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h7B, 32'h02, "bus pending");
         rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h7B, 32'h02, "bus reread");
         m.pulse(4, 1);
         rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h02, 32'h00, "bus cleared");
      end
      for (int i = 0; i < DMA_CONDS; i++)
      begin
         m.raise(8'h00, 4'h1 << i);
         rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h03, 32'h01, "dma pending");
         m.pulse(5, 1);
         rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h01, 32'h00, "dma cleared");
      end
      wb(1'b1, IDX_INTERRUPT_STATUS_ABORT, 4'h1, 32'h78);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'hF8, 32'h00, "reserved");
   endtask

   task t_abort;
      wb(1'b1, IDX_INTERRUPT_STATUS_ABORT, 4'h1, 32'h80);
      check("abort out", abort_request, 32'h1);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h83, 32'h81, "abort dma");
      m.pulse(5, 1);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h01, 32'h01, "abort repeats");
      wb(1'b1, IDX_INTERRUPT_STATUS_ABORT, 4'h1, 32'h00);
      m.pulse(5, 1);
      rdchk(IDX_INTERRUPT_STATUS_ABORT, 32'h83, 32'h00, "abort over");
      check("abort off", abort_request, 32'h0);
   endtask

   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      check("reset outs", {flush_request, abort_request, differential_select, fifo_pointers_clear}, 32'h0);
      t_regs;
      t_stack;
      t_fifo;
      t_bcnt;
      t_residual;
      t_status;
      t_abort;
      wrap_up;
   end
endmodule
